// ### rtl/program_memory_decode_map.vh
// address map constants for the program memory decoder
`ifndef PROGRAM_MEMORY_DECODE_MAP_VH
`define PROGRAM_MEMORY_DECODE_MAP_VH
`define OPTION_BYTES_LO 16'h0000
`define OPTION_BYTES_HI 16'h0001
`define RESET_VEC_LO 16'h0002
`define RESET_VEC_HI 16'h0003
`define WDT_VEC_LO 16'h0004
`define WDT_VEC_HI 16'h0005
`define ILL_TRAP_LO 16'h0006
`define ILL_TRAP_HI 16'h0007
`define IRQ_VEC_LO 16'h0008
`define IRQ_VEC_HI 16'h0037
`define RSVD_LO 16'h0038
`define RSVD_HI 16'h0039
`define OSC_TRAP_LO 16'h003A
`define OSC_TRAP_HI 16'h003D
`define APP_CODE_LO 16'h003E
`define TOP_8K 16'h1FFF
`define TOP_4K 16'h0FFF
`define TOP_2K 16'h07FF
`define TOP_1K 16'h03FF
`define INFO_LO 16'hFE00
`define INFO_HI 16'hFF7F
`define INFO_EN_BIT 7
`define UNIMPL_BYTE 8'hFF
`define PAGE_SEL_RESET 8'h00
`define REGION_OPTION 3'h0
`define REGION_RESET 3'h1
`define REGION_WDT 3'h2
`define REGION_TRAP 3'h3
`define REGION_IRQ 3'h4
`define REGION_RSVD 3'h5
`define REGION_OSC 3'h6
`define REGION_CODE 3'h7
`endif

// ### rtl/byte_array_mem.v
// synchronous single-port byte memory with registered read data
`timescale 1ns/100ps
module byte_array_mem #(
   parameter AW = 13,
   parameter DEPTH = 8192
) (
   clk,
   we,
   addr,
   wdata,
   rdata
);
   input wire clk;
   input wire we;
   input wire [AW-1:0] addr;
   input wire [7:0] wdata;
   output reg [7:0] rdata;

   reg [7:0] mem [0:DEPTH-1];

   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ### rtl/program_memory_decode.v
// program memory address decoder with information area overlay
`timescale 1ns/100ps
`include "program_memory_decode_map.vh"

// Functional notes
// [R1] reads above top of flash return FFH, except in the enabled overlay window
// [R2] writes to unimplemented addresses are discarded
// [R3] fixed option, vector, trap layout below 003EH
// [R4] top address chosen by size parameter
// [R5] info area enabled by page-select bit 7
// [R6] overlay covers FE00H through FF7FH only
// [R7] overlaid reads return information area bytes
// [R8] no data-memory space decoded
// [R9] implemented reads return array byte, one cycle
module program_memory_decode #(
   parameter SIZE_SEL = 2'd0,
   parameter INFO_DEPTH = 128
) (
   clk,
   rst_n,
   pm_addr,
   pm_rd,
   pm_wr,
   pm_wdata,
   pm_rdata,
   pm_rvalid,
   page_sel_wr,
   page_sel_wdata,
   page_sel_rdata,
   info_en,
   region
);
   input wire clk;
   input wire rst_n;
   input wire [15:0] pm_addr;
   input wire pm_rd;
   input wire pm_wr;
   input wire [7:0] pm_wdata;
   output reg [7:0] pm_rdata;
   output reg pm_rvalid;
   input wire page_sel_wr;
   input wire [7:0] page_sel_wdata;
   output wire [7:0] page_sel_rdata;
   output wire info_en;
   output reg [2:0] region;

   // size select: 0 = 8K, 1 = 4K, 2 = 2K, 3 = 1K
   reg [15:0] top_addr;
   always @* begin
      case (SIZE_SEL)
         2'd0: top_addr = `TOP_8K; // R4
         2'd1: top_addr = `TOP_4K; // R4
         2'd2: top_addr = `TOP_2K; // R4
         2'd3: top_addr = `TOP_1K; // R4
         default: top_addr = `TOP_8K;
      endcase
   end

   reg [7:0] page_sel_q;
   reg [7:0] page_sel_d;
   always @* begin
      if (page_sel_wr) begin
         page_sel_d = page_sel_wdata;
      end else begin
         page_sel_d = page_sel_q;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         page_sel_q <= `PAGE_SEL_RESET;
      end else begin
         page_sel_q <= page_sel_d; // R5
      end
   end
   assign page_sel_rdata = page_sel_q;
   assign info_en = page_sel_q[`INFO_EN_BIT]; // R5

   // only the program-memory port exists; no data-memory space // R8
   wire in_window;
   wire in_info;
   wire in_main;
   assign in_window = (pm_addr >= `INFO_LO) && (pm_addr <= `INFO_HI); // R6
   assign in_info = info_en && in_window; // R5
   assign in_main = (pm_addr <= top_addr); // R4

   wire main_we = pm_wr && in_main && !in_info; // R2
   wire info_we = pm_wr && in_info; // R2

   wire [7:0] main_q;
   wire [7:0] info_q;
   wire [12:0] main_idx;
   wire [6:0] info_idx;
   assign main_idx = pm_addr[12:0];
   assign info_idx = pm_addr[6:0]; // R6

   byte_array_mem #(
      .AW(13),
      .DEPTH(8192)
   ) u_main (
      .clk(clk),
      .we(main_we),
      .addr(main_idx),
      .wdata(pm_wdata),
      .rdata(main_q)
   );

   byte_array_mem #(
      .AW(7),
      .DEPTH(INFO_DEPTH)
   ) u_info (
      .clk(clk),
      .we(info_we),
      .addr(info_idx),
      .wdata(pm_wdata),
      .rdata(info_q)
   );

   localparam [1:0] SEL_BLANK = 2'h0;
   localparam [1:0] SEL_MAIN = 2'h1;
   localparam [1:0] SEL_INFO = 2'h2;

   reg [1:0] sel_q;
   reg [1:0] sel_d;
   reg rd_q;
   always @* begin
      if (in_info) begin
         sel_d = SEL_INFO; // R7
      end else if (in_main) begin
         sel_d = SEL_MAIN; // R9
      end else begin
         sel_d = SEL_BLANK; // R1
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         sel_q <= SEL_BLANK;
         rd_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
         rd_q <= pm_rd; // R9
      end
   end

   always @* begin
      case (sel_q)
         SEL_MAIN: pm_rdata = main_q; // R9
         SEL_INFO: pm_rdata = info_q; // R7
         default: pm_rdata = `UNIMPL_BYTE; // R1
      endcase
   end

   always @* begin
      pm_rvalid = rd_q; // R9
   end

   // region classification of the current address
   wire hit_option;
   wire hit_reset;
   wire hit_wdt;
   wire hit_trap;
   wire hit_irq;
   wire hit_rsvd;
   wire hit_osc;
   assign hit_option = (pm_addr <= `OPTION_BYTES_HI); // R3
   assign hit_reset = (pm_addr >= `RESET_VEC_LO) && (pm_addr <= `RESET_VEC_HI); // R3
   assign hit_wdt = (pm_addr >= `WDT_VEC_LO) && (pm_addr <= `WDT_VEC_HI); // R3
   assign hit_trap = (pm_addr >= `ILL_TRAP_LO) && (pm_addr <= `ILL_TRAP_HI); // R3
   assign hit_irq = (pm_addr >= `IRQ_VEC_LO) && (pm_addr <= `IRQ_VEC_HI); // R3
   assign hit_rsvd = (pm_addr >= `RSVD_LO) && (pm_addr <= `RSVD_HI); // R3
   assign hit_osc = (pm_addr >= `OSC_TRAP_LO) && (pm_addr <= `OSC_TRAP_HI); // R3

   reg [2:0] region_d;
   always @* begin
      case (1'b1)
         hit_option: region_d = `REGION_OPTION;
         hit_reset: region_d = `REGION_RESET;
         hit_wdt: region_d = `REGION_WDT;
         hit_trap: region_d = `REGION_TRAP;
         hit_irq: region_d = `REGION_IRQ;
         hit_rsvd: region_d = `REGION_RSVD;
         hit_osc: region_d = `REGION_OSC;
         default: region_d = `REGION_CODE; // R3
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         region <= `REGION_OPTION;
      end else begin
         region <= region_d; // R3
      end
   end
endmodule

// ### tb/core_model.sv
// processor core model issuing program memory accesses
`timescale 1ns/100ps
module core_model (
   input wire clk,
   output reg [15:0] pm_addr,
   output reg pm_rd,
   output reg pm_wr,
   output reg [7:0] pm_wdata
);
   initial {pm_addr, pm_rd, pm_wr, pm_wdata} = 26'h0;
   task acc(input w, input [15:0] a, input [7:0] d);
      begin
         @(negedge clk);
         {pm_rd, pm_wr, pm_addr, pm_wdata} <= {!w, w, a, d};
         @(negedge clk);
         {pm_rd, pm_wr, pm_addr, pm_wdata} <= {2'b00, ~a, ~d};
      end
   endtask
endmodule

// ### tb/program_memory_decode_assertions.sv
// port checks for the program memory decoder
`timescale 1ns/100ps
module pm_decode_checks #(parameter SIZE_SEL = 2'd0) (
   input wire clk,
   input wire rst_n,
   input wire [15:0] pm_addr,
   input wire pm_rd,
   input wire [7:0] pm_rdata,
   input wire pm_rvalid,
   input wire page_sel_wr,
   input wire [7:0] page_sel_wdata,
   input wire [7:0] page_sel_rdata,
   input wire info_en,
   input wire [2:0] region
);
   localparam [15:0] TOP = 16'h1FFF >> SIZE_SEL;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_RV: assert property (pm_rd |=> pm_rvalid) else $error("no rvalid");
   AST_NORV: assert property (!pm_rd |=> !pm_rvalid) else $error("stray rvalid");
   AST_TOP: assert property (pm_rd && pm_addr > TOP && !info_en |=> pm_rdata == 8'hFF)
      else $error("unimplemented read not FF");
   AST_HI: assert property (pm_rd && pm_addr >= 16'hFF80 |=> pm_rdata == 8'hFF)
      else $error("read above overlay not FF");
   AST_PS: assert property (page_sel_wr |=> page_sel_rdata == $past(page_sel_wdata))
      else $error("page select not loaded");
   AST_EN: assert property (page_sel_wr |=> info_en == $past(page_sel_wdata[7]))
      else $error("info_en not loaded");
   AST_OPT: assert property (pm_addr < 16'h0002 |=> region == 3'h0) else $error("region opt");
   AST_VEC: assert property (pm_addr >= 16'h0002 && pm_addr <= 16'h0007
      |=> region == {1'b0, $past(pm_addr[2:1])}) else $error("region vector");
   AST_IRQ: assert property (pm_addr inside {[16'h0008:16'h0037]} |=> region == 3'h4)
      else $error("region irq");
   AST_RSVD: assert property (pm_addr inside {[16'h0038:16'h0039]} |=> region == 3'h5)
      else $error("region reserved");
   AST_OSC: assert property (pm_addr inside {[16'h003A:16'h003D]} |=> region == 3'h6)
      else $error("region osc");
   AST_CODE: assert property (pm_addr >= 16'h003E |=> region == 3'h7) else $error("region code");
endmodule
bind program_memory_decode pm_decode_checks #(.SIZE_SEL(SIZE_SEL)) chk_i (.clk(clk),
   .rst_n(rst_n), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata), .pm_rvalid(pm_rvalid),
   .page_sel_wr(page_sel_wr), .page_sel_wdata(page_sel_wdata),
   .page_sel_rdata(page_sel_rdata), .info_en(info_en), .region(region));

// ### tb/tb_top.sv
// self-checking bench for the program memory decoder
`timescale 1ns/100ps
module tb_top;
   localparam [15:0] TOP = 16'h0FFF;
   localparam [15:0] LAY [0:10] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008,
      16'h0038, 16'h003A, 16'h003E, 16'h0FFF, 16'h1000, 16'hE000};
   localparam [15:0] INF [0:3] = '{16'hFDFF, 16'hFE00, 16'hFF7F, 16'hFF80};
   reg clk = 0, rst_n = 0, page_sel_wr = 0, ov = 0;
   reg [7:0] page_sel_wdata = 8'h00;
   wire [15:0] pm_addr;
   wire pm_rd, pm_wr, pm_rvalid, info_en;
   wire [7:0] pm_wdata, pm_rdata, page_sel_rdata;
   wire [2:0] region;
   reg [7:0] mm [int], im [int], q [$];
   reg [31:0] s = 32'h926C;
   integer n_fail = 0, checks = 0, i;
   core_model core (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr),
      .pm_wdata(pm_wdata));
   program_memory_decode #(.SIZE_SEL(2'd1)) dut (.clk(clk), .rst_n(rst_n), .pm_addr(pm_addr),
      .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
      .pm_rvalid(pm_rvalid), .page_sel_wr(page_sel_wr), .page_sel_wdata(page_sel_wdata),
      .page_sel_rdata(page_sel_rdata), .info_en(info_en), .region(region));
   task automatic chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   function bit inov(input [15:0] a);
      inov = ov && a >= 16'hFE00 && a <= 16'hFF7F;
   endfunction
   task wr(input [15:0] a);
      begin
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
         if (inov(a)) im[a] = s[7:0];
         else if (a <= TOP) mm[a] = s[7:0];
         core.acc(1'b1, a, s[7:0]);
      end
   endtask
   task rd(input [15:0] a);
      begin
         q.push_back(inov(a) ? im[a] : (a <= TOP ? mm[a] : 8'hFF));
         core.acc(1'b0, a, 8'h00);
      end
   endtask
   task ps(input [7:0] d);
      begin
         @(negedge clk);
         {page_sel_wr, page_sel_wdata} <= {1'b1, d};
         @(negedge clk);
         page_sel_wr <= 1'b0;
         ov = d[7];
         chk("page_sel_rdata", page_sel_rdata, d);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   always @(negedge clk) if (pm_rvalid === 1'b1) chk("pm_rdata", pm_rdata, q.pop_front());
   initial forever #4 clk = ~clk;
   initial begin
      #20000;
      n_fail = n_fail + 1;
      wrap_up;
   end
   initial begin
      repeat (10) @(negedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 11; i = i + 1) wr(LAY[i]);
      for (i = 0; i < 11; i = i + 1) rd(LAY[i]);
      $display("test map done");
      ps(8'h80);
      for (i = 0; i < 4; i = i + 1) wr(INF[i]);
      for (i = 0; i < 4; i = i + 1) rd(INF[i]);
      ps(8'h00);
      for (i = 0; i < 4; i = i + 1) rd(INF[i]);
      $display("test overlay done");
      for (i = 0; i < 8 && q.size() > 0; i = i + 1) @(negedge clk);
      chk("reads pending", {7'h00, q.size() != 0}, 8'h00);
      wrap_up;
   end
endmodule
